// >>> core/ext_irq_defines.svh
// Offsets, field positions, reset values and vector constants for the
// external interrupt sensitivity block. Included by bare name.
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

`define OFS_EXT_IRQ_CONTROL 8'h00
`define OFS_IRQ_STATUS      8'h04
`define OFS_IRQ_CONTROL     8'h08
`define OFS_VECTOR          8'h0C
`define RST_EXT_IRQ_CONTROL 8'h00
`define BIT_TOP_ENABLE      0
`define BIT_TOP_EDGE        1
`define BIT_PORTA_INVERT    2
`define LSB_PORTAF_SENSE    3
`define BIT_PORTB_INVERT    5
`define LSB_PORTB_SENSE     6
`define NUM_SOURCES         14
`define VEC_RESET           16'hFFFE
`define VEC_TRAP            16'hFFFC
`define VEC_BASE            16'hFFFA
`define WAKE_FIXED          14'h003F

`endif

// >>> core/ext_irq_pkg.sv
// Types shared by the external interrupt sensitivity block.
// Assumes nothing beyond the defines header.
package ext_irq_pkg;

  typedef enum logic [1:0] {
    SENSE_FALL_LOW = 2'b00,
    SENSE_RISE     = 2'b01,
    SENSE_FALL     = 2'b10,
    SENSE_BOTH     = 2'b11
  } sense_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } bus_state_t;

endpackage : ext_irq_pkg

// >>> core/pin_group_if.sv
// Carrier between a pin group detector and the main block.
// Assumes one clock domain, clk_sys.
`timescale 1ns/1ps
interface pin_group_if #(parameter int PINS = 4);
  logic [PINS-1:0] pins;
  logic [1:0]      sense;
  logic            invert;
  logic            clear;
  logic            request;
  modport detector (input pins, input sense, input invert, input clear, output request);
  modport owner    (output pins, output sense, output invert, output clear, input request);
endinterface : pin_group_if

// >>> core/pin_group_detect.sv
// One external pin group: synchroniser, edge and level detect, OR and latch.
// Assumes pins may be asynchronous to clk_sys and the owner pulses clear on service.
`timescale 1ns/1ps
module pin_group_detect
  import ext_irq_pkg::*;
#(
  parameter int PINS = 4
)(
  input wire logic    clk_sys,
  input wire logic    rst,
  pin_group_if.detector grp
);

  typedef struct packed {
    logic [PINS-1:0] sync1;
    logic [PINS-1:0] sync2;
    logic [PINS-1:0] prev;
    logic            latched;
  } state_t;

  state_t cur;
  state_t next_s;
  logic [PINS-1:0] rise;
  logic [PINS-1:0] fall;
  logic            edge_hit;
  logic            level_hit;

  always_comb
  begin
    next_s       = cur;
    next_s.sync1 = grp.pins;
    next_s.sync2 = cur.sync1;
    next_s.prev  = cur.sync2;
    rise         = cur.sync2 & ~cur.prev;
    fall         = ~cur.sync2 & cur.prev;
    level_hit    = 1'b0;
    edge_hit     = 1'b0;
    // Inversion swaps rise and fall; level follows
    unique case (sense_t'(grp.sense))
      SENSE_FALL_LOW:
      begin
        edge_hit  = grp.invert ? |rise : |fall;
        level_hit = grp.invert ? |cur.sync2 : |(~cur.sync2);
      end
      SENSE_RISE: edge_hit = grp.invert ? |fall : |rise;
      SENSE_FALL: edge_hit = grp.invert ? |rise : |fall;
      SENSE_BOTH: edge_hit = |(rise | fall);
    endcase
    // Set wins over clear
    if (edge_hit)
      next_s.latched = 1'b1;
    else if (grp.clear)
      next_s.latched = 1'b0;
    grp.request = cur.latched | level_hit;
  end

  always_ff @(posedge clk_sys)
  begin
    // Idle-high start, so a quiet high pin gives no low level after reset
    if (rst)
      cur <= '{sync1: '1, sync2: '1, prev: '1, latched: 1'b0};
    else
      cur <= next_s;
  end

endmodule : pin_group_detect

// >>> core/ext_irq_ahb.sv
// AHB-Lite front end for the external interrupt sensitivity block.
// Notes on behaviour
// - Top pin vector FFFAh, wakes from both stop modes.
// - Clock time base vector FFF8h, wakes from both stop modes.
// - Four port groups use vectors FFF6h down to FFF0h, all wake.
// - Serial peripheral interface vector FFECh wakes only in slave mode.
// - PWM timer vector FFE0h wakes only on external clock.
// - Timers, serial port, voltage detector, I2C never wake.
// - Up to two independent sensitivity settings for external groups.
// - Port B field bits 7:6 select fall+low, rise, fall, both.
// - Port A/F field bits 4:3 uses the same encodings.
// - Polarity bits 5 and 2 invert the low nibble group sense.
// - Rise plus high level only on port A and B low groups.
// - Sense and polarity writes accepted only at priority level 3.
// - Changing a sense field or polarity bit clears latched port group requests.
// - Bit 1 selects top pin edge, changeable only while disabled.
// - Bit 0 enables the top pin interrupt, freely writable.
// - A spurious top pin request may appear when enable clears.
// - Control register is eight bits, read/write, resets to zero.
// - Events of pins in one group are ORed onto one line.
// - Edge events latch and clear on entering the service routine.
// Assumes a single AHB-Lite master, word transfers, and a CPU that
// drives priority bits, service strobes and peripheral requests.
`timescale 1ns/1ps
`include "ext_irq_defines.svh"
module ext_irq_ahb
  import ext_irq_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cur_prio_hi,
  input  wire logic        cur_prio_lo,
  input  wire logic [3:0]  porta_pins,
  input  wire logic [2:0]  portf_pins,
  input  wire logic [3:0]  portb_lo_pins,
  input  wire logic [3:0]  portb_hi_pins,
  input  wire logic        top_pin,
  input  wire logic [7:0]  periph_irq,
  input  wire logic        spi_slave_mode,
  input  wire logic        pwm_ext_clock,
  input  wire logic        trap_req,
  input  wire logic        reset_req,
  input  wire logic        service_ack,
  input  wire logic        in_stop_mode,
  output logic             top_level_pin_irq,
  output logic             porta_low_group_irq,
  output logic             portf_low_group_irq,
  output logic             portb_low_group_irq,
  output logic             portb_high_group_irq,
  output logic             irq_pending,
  output logic [15:0]      irq_vector,
  output logic             wake_req
);

  typedef struct packed {
    bus_state_t  bus;
    logic [7:0]  addr;
    logic [7:0]  ctrl;
    logic        clear_pend;
    logic [2:0]  top_sync;
    logic        top_latched;
    logic [31:0] hrdata;
    logic        top_irq;
    logic [3:0]  grp_irq;
    logic        pending;
    logic [15:0] vector;
    logic        wake;
  } state_t;

  state_t cur;
  state_t next_s;

  pin_group_if #(.PINS(4)) g_pa ();
  pin_group_if #(.PINS(3)) g_pf ();
  pin_group_if #(.PINS(4)) g_pbl ();
  pin_group_if #(.PINS(4)) g_pbh ();

  // Sources 2..5 are the pin groups; 6 is unused
  logic [`NUM_SOURCES-1:0] src;
  logic [`NUM_SOURCES-1:0] wake_mask;
  logic                    level3;
  logic                    top_edge;
  logic [7:0]              wdata;
  logic [7:0]              new_ctrl;

  pin_group_detect #(.PINS(4)) u_pa  (.clk_sys(clk_sys), .rst(rst), .grp(g_pa));
  pin_group_detect #(.PINS(3)) u_pf  (.clk_sys(clk_sys), .rst(rst), .grp(g_pf));
  pin_group_detect #(.PINS(4)) u_pbl (.clk_sys(clk_sys), .rst(rst), .grp(g_pbl));
  pin_group_detect #(.PINS(4)) u_pbh (.clk_sys(clk_sys), .rst(rst), .grp(g_pbh));

  // Lowest index wins; one encoder serves both vector and wake choice
  function automatic logic [15:0] pick_vector(input logic [`NUM_SOURCES-1:0] req);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = `NUM_SOURCES - 1; i >= 0; i--)
      if (req[i])
        v = 16'(`VEC_BASE - 16'(2 * i));
    return v;
  endfunction : pick_vector

  assign g_pa.pins   = porta_pins;
  assign g_pa.sense  = cur.ctrl[`LSB_PORTAF_SENSE +: 2];
  assign g_pa.invert = cur.ctrl[`BIT_PORTA_INVERT];
  assign g_pa.clear  = cur.clear_pend | (service_ack && irq_vector == 16'hFFF6);
  assign g_pf.pins   = portf_pins;
  assign g_pf.sense  = cur.ctrl[`LSB_PORTAF_SENSE +: 2];
  assign g_pf.invert = 1'b0;
  assign g_pf.clear  = cur.clear_pend | (service_ack && irq_vector == 16'hFFF4);
  assign g_pbl.pins   = portb_lo_pins;
  assign g_pbl.sense  = cur.ctrl[`LSB_PORTB_SENSE +: 2];
  assign g_pbl.invert = cur.ctrl[`BIT_PORTB_INVERT];
  assign g_pbl.clear  = cur.clear_pend | (service_ack && irq_vector == 16'hFFF2);
  assign g_pbh.pins   = portb_hi_pins;
  assign g_pbh.sense  = cur.ctrl[`LSB_PORTB_SENSE +: 2];
  assign g_pbh.invert = 1'b0;
  assign g_pbh.clear  = cur.clear_pend | (service_ack && irq_vector == 16'hFFF0);

  always_comb
  begin
    next_s            = cur;
    next_s.clear_pend = 1'b0;
    level3            = cur_prio_hi & cur_prio_lo;
    wdata             = hwdata[7:0];
    new_ctrl          = cur.ctrl;
    // Bus address phase
    if (hsel && hready && htrans[1])
    begin
      next_s.addr = haddr;
      next_s.bus  = hwrite ? BUS_WRITE : BUS_READ;
    end
    else if (hready)
      next_s.bus = BUS_IDLE;
    // Data phase write
    if (cur.bus == BUS_WRITE && cur.addr == `OFS_EXT_IRQ_CONTROL)
    begin
      new_ctrl[`BIT_TOP_ENABLE] = wdata[`BIT_TOP_ENABLE];
      if (!cur.ctrl[`BIT_TOP_ENABLE])
        new_ctrl[`BIT_TOP_EDGE] = wdata[`BIT_TOP_EDGE];
      if (level3)
        new_ctrl[7:2] = wdata[7:2];
      if (new_ctrl[7:2] != cur.ctrl[7:2])
        next_s.clear_pend = 1'b1;
      next_s.ctrl = new_ctrl;
    end
    // Top pin: sync, edge select, latch
    next_s.top_sync = {cur.top_sync[1:0], top_pin};
    top_edge = cur.ctrl[`BIT_TOP_EDGE] ? (cur.top_sync[1] & ~cur.top_sync[2])
                                       : (~cur.top_sync[1] & cur.top_sync[2]);
    // Clearing enable drops the latch a cycle late, so one stale request
    // may still show; the CPU side must accept it
    if (top_edge && cur.ctrl[`BIT_TOP_ENABLE])
      next_s.top_latched = 1'b1;
    else if (service_ack && cur.vector == `VEC_BASE)
      next_s.top_latched = 1'b0;
    else if (!cur.ctrl[`BIT_TOP_ENABLE])
      next_s.top_latched = 1'b0;
    src     = {periph_irq[7:1], 1'b0, g_pbh.request, g_pbl.request, g_pf.request,
               g_pa.request, periph_irq[0], cur.top_latched};
    wake_mask    = `WAKE_FIXED;
    wake_mask[7] = spi_slave_mode;
    wake_mask[13] = pwm_ext_clock;
    next_s.top_irq = cur.top_latched;
    next_s.grp_irq = {g_pbh.request, g_pbl.request, g_pf.request, g_pa.request};
    // In stop a pending request must be one that can be chosen
    next_s.pending = reset_req | trap_req | (in_stop_mode ? |(src & wake_mask) : |src);
    // In stop, reset and trap still come first; after them only waking sources may be chosen
    if (reset_req)
      next_s.vector = `VEC_RESET;
    else if (trap_req)
      next_s.vector = `VEC_TRAP;
    else if (in_stop_mode)
      next_s.vector = pick_vector(src & wake_mask);
    else
      next_s.vector = pick_vector(src);
    next_s.wake = |(src & wake_mask);
    // Read data
    unique case (next_s.addr)
      `OFS_EXT_IRQ_CONTROL: next_s.hrdata = {24'h000000, next_s.ctrl};
      `OFS_IRQ_STATUS:      next_s.hrdata = {18'h00000, src};
      `OFS_VECTOR:          next_s.hrdata = {16'h0000, cur.vector};
      default:              next_s.hrdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cur <= '0;
    else
      cur <= next_s;
  end

  assign hrdata               = cur.hrdata;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign top_level_pin_irq    = cur.top_irq;
  assign porta_low_group_irq  = cur.grp_irq[0];
  assign portf_low_group_irq  = cur.grp_irq[1];
  assign portb_low_group_irq  = cur.grp_irq[2];
  assign portb_high_group_irq = cur.grp_irq[3];
  assign irq_pending          = cur.pending;
  assign irq_vector           = cur.vector;
  assign wake_req             = cur.wake;

endmodule : ext_irq_ahb

// >>> testbench/ext_irq_asserts.sv
// Checker on the top-level ports of the sensitivity block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module ext_irq_asserts
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        top_pin,
  input wire logic        reset_req,
  input wire logic        trap_req,
  input wire logic        in_stop_mode,
  input wire logic        spi_slave_mode,
  input wire logic        pwm_ext_clock,
  input wire logic        top_level_pin_irq,
  input wire logic        irq_pending,
  input wire logic [15:0] irq_vector
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  a_reset_quiet: assert property ($fell(rst) |-> !irq_pending && !top_level_pin_irq)
    else $error("request right after reset");
  a_vector_span: assert property (irq_pending |-> !irq_vector[0] && irq_vector >= 16'hFFE0)
    else $error("vector outside map");
  a_reset_wins: assert property (reset_req [*2] |-> irq_pending && irq_vector == 16'hFFFE)
    else $error("reset source not first");
  a_trap_next: assert property ((trap_req && !reset_req && !in_stop_mode) [*2] |->
    irq_vector == 16'hFFFC) else $error("trap source not above numbered");
  a_stop_no_timer: assert property (in_stop_mode && $past(in_stop_mode) && irq_pending |->
    !(irq_vector inside {[16'hFFE2:16'hFFEA]})) else $error("non-wake source in stop");
  a_stop_spi_slave: assert property (in_stop_mode && $past(in_stop_mode) && irq_pending &&
    irq_vector == 16'hFFEC |-> $past(spi_slave_mode)) else $error("spi wake as master");
  a_stop_pwm_ext: assert property (in_stop_mode && $past(in_stop_mode) && irq_pending &&
    irq_vector == 16'hFFE0 |-> $past(pwm_ext_clock)) else $error("pwm wake on inner clock");
  // Window covers sync, edge and output register delay
  a_top_after_edge: assert property ($rose(top_level_pin_irq) |->
    $past(top_pin, 1) != $past(top_pin, 2) || $past(top_pin, 2) != $past(top_pin, 3) ||
    $past(top_pin, 3) != $past(top_pin, 4) || $past(top_pin, 4) != $past(top_pin, 5))
    else $error("top request without pin edge");
  c_top_request: cover property ($rose(top_level_pin_irq));
  c_stop_pending: cover property (in_stop_mode && irq_pending);
  c_reset_source: cover property (reset_req && irq_pending);
endmodule : ext_irq_asserts

bind ext_irq_ahb ext_irq_asserts chk (.clk_sys, .rst, .hreadyout, .hresp, .top_pin,
  .reset_req, .trap_req, .in_stop_mode, .spi_slave_mode, .pwm_ext_clock,
  .top_level_pin_irq, .irq_pending, .irq_vector);

// >>> testbench/ext_pin_model.sv
// Far-side model: the four port pin groups and the top pin.
// Assumes levels are requested just after a clk_sys rising edge.
`timescale 1ns/1ps
module ext_pin_model
(
  input  wire logic        clk_sys,
  input  wire logic [15:0] level,
  output logic [3:0]       porta_pins,
  output logic [2:0]       portf_pins,
  output logic [3:0]       portb_lo_pins,
  output logic [3:0]       portb_hi_pins,
  output logic             top_pin
);
  // Pins move one edge late, like a real asynchronous source
  always_ff @(posedge clk_sys)
    {top_pin, portb_hi_pins, portb_lo_pins, portf_pins, porta_pins} <= level;
endmodule : ext_pin_model

// >>> testbench/tb_top.sv
// Self-checking bench for the sensitivity block and vector map.
// Assumes the design files compile first; single AHB-Lite master.
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys = 1'b0, rst = 1'b1, hwrite = 1'b0, cur_prio_hi = 1'b0;
  logic        cur_prio_lo = 1'b0, spi_slave_mode = 1'b0, pwm_ext_clock = 1'b0;
  logic        trap_req = 1'b0, reset_req = 1'b0, service_ack = 1'b0, in_stop_mode = 1'b0;
  logic [1:0]  htrans = 2'b00, code;
  logic [7:0]  haddr = 8'h00, periph_irq = 8'h00, v;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic [15:0] level = 16'hFFFF, lvl, irq_vector;
  logic [3:0]  porta_pins, portb_lo_pins, portb_hi_pins, idle, hit, grp;
  logic [2:0]  portf_pins;
  logic        hreadyout, hresp, top_pin, top_level_pin_irq, porta_low_group_irq, ig;
  logic        portf_low_group_irq, portb_low_group_irq, portb_high_group_irq, irq_pending;
  logic        wake_req;
  logic [10:0] rnd;
  logic [16:0] e;
  int          failures = 0, tests_run = 0, cycles = 0;
  int          lo[4] = '{0, 4, 7, 11};
  int          w[4] = '{4, 3, 4, 4};
  assign grp = {portb_high_group_irq, portb_low_group_irq, portf_low_group_irq,
                porta_low_group_irq};
  initial forever #12.5 clk_sys = ~clk_sys;
  ext_pin_model far_pins (.clk_sys, .level, .porta_pins, .portf_pins, .portb_lo_pins,
    .portb_hi_pins, .top_pin);
  ext_irq_ahb DUT (.clk_sys, .rst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cur_prio_hi, .cur_prio_lo,
    .porta_pins, .portf_pins, .portb_lo_pins, .portb_hi_pins, .top_pin, .periph_irq,
    .spi_slave_mode, .pwm_ext_clock, .trap_req, .reset_req, .service_ack, .in_stop_mode,
    .top_level_pin_irq, .porta_low_group_irq, .portf_low_group_irq, .portb_low_group_irq,
    .portb_high_group_irq, .irq_pending, .irq_vector, .wake_req);
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : ticks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr_en;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    q = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    check(q, x);
  endtask : rd
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  // Lowest numbered source wins; only wake-capable ones count in stop
  function automatic logic [16:0] exp_vec(input logic [7:0] p, input logic s, sp, pw, tr, rs);
    int n;
    n = 99;
    for (int k = 7; k >= 0; k--)
      if (p[k] && (!s || k == 0 || (k == 1 && sp) || (k == 7 && pw))) n = (k == 0) ? 1 : k + 6;
    if (rs)
      return {1'b1, 16'hFFFE};
    if (tr && !s)
      return {1'b1, 16'hFFFC};
    return (n == 99) ? 17'h0 : {1'b1, 16'hFFFA - 16'(2 * n)};
  endfunction : exp_vec
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      conclude();
    end
  end
  initial
  begin
    rnd = $urandom(98);
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      rnd = $urandom;
      rnd[2:0] = rnd[2:0] & rnd[5:3];
      {in_stop_mode, spi_slave_mode, pwm_ext_clock, periph_irq} <= {rnd[10] && i > 1, rnd[9:0]};
      {reset_req, trap_req} <= {i == 0, i == 1};
      ticks(4);
      e = exp_vec(rnd[7:0], rnd[10] && i > 1, rnd[9], rnd[8], i == 1, i == 0);
      check({15'h0, irq_pending, e[16] ? irq_vector : 16'h0}, {15'h0, e});
      check({31'h0, wake_req}, {31'h0, rnd[0] | (rnd[1] & rnd[9]) | (rnd[7] & rnd[8])});
    end
    {in_stop_mode, spi_slave_mode, pwm_ext_clock, periph_irq, reset_req, trap_req} <= 13'h0;
    $display("test vector map done");
    bus(1'b1, 8'h00, 32'h01);
    level[15] <= 1'b0;
    ticks(8);
    check({15'h0, top_level_pin_irq, irq_vector}, {15'h0, 1'b1, 16'hFFFA});
    bus(1'b1, 8'h00, 32'hFF);
    rd(8'h00, 32'h01);
    bus(1'b1, 8'h00, 32'h00);
    ticks(3);
    check({31'h0, top_level_pin_irq}, 32'h0);
    bus(1'b1, 8'h00, 32'h02);
    rd(8'h00, 32'h02);
    bus(1'b1, 8'h00, 32'h03);
    level[15] <= 1'b1;
    ticks(8);
    check({31'h0, top_level_pin_irq}, 32'h1);
    bus(1'b1, 8'h00, 32'h02);
    $display("test top pin done");
    {cur_prio_hi, cur_prio_lo} <= 2'b11;
    lvl = 16'hFFFF;
    for (int i = 0; i < 8; i++)
    begin
      code = i[1:0];
      v = {code, i[2], code, i[2], 2'b00};
      rnd = $urandom;
      for (int g = 0; g < 4; g++)
      begin
        ig = i[2] && (g % 2 == 0);
        idle[g] = (code == 2'b00) ? !ig : rnd[0];
        for (int b = 0; b < w[g]; b++) lvl[lo[g] + b] = idle[g];
        hit[g] = code == 2'b00 || code == 2'b11 || (code[0] ? !idle[g] ^ ig : idle[g] ^ ig);
      end
      level <= lvl;
      ticks(8);
      bus(1'b1, 8'h00, {24'h0, v});
      ticks(6);
      check({28'h0, grp}, 32'h0);
      for (int g = 0; g < 4; g++) lvl[lo[g] + $urandom % w[g]] ^= 1'b1;
      level <= lvl;
      ticks(8);
      check({28'h0, grp}, {28'h0, hit});
    end
    rd(8'h00, 32'hFC);
    check({16'h0, irq_vector}, 32'hFFF6);
    service_ack <= 1'b1;
    @(posedge clk_sys);
    service_ack <= 1'b0;
    ticks(4);
    check({15'h0, porta_low_group_irq, irq_vector}, {16'h0, 16'hFFF4});
    $display("test pin groups done");
    conclude();
  end
endmodule : tb_top
